// ===== hdl/gpi_trigger_pkg.sv
/*
 constants for the pin-triggered action dispatcher: register offsets,
 field positions, reset values, function codes and timing counts.
 assumes a 32-bit axi4-lite register bus with byte addressing.
*/
package gpi_trigger_pkg;
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_VPD_SETTING = 8'h04;
	localparam logic [7:0] ADDR_SW_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	// config register fields
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_CODE_LSB = 4;
	localparam int CFG_MASK_LSB = 8;
	// software control fields
	localparam int SW_FAULT_BIT = 0;
	localparam int SW_PROTECT_BIT = 1;
	localparam int SW_IPD_LSB = 8;
	localparam int SW_VPD_LSB = 16;
	// status fields
	localparam int ST_LEVEL_BIT = 0;
	localparam int ST_BOOT_DONE_BIT = 1;
	localparam int ST_IPD_LSB = 8;
	localparam int ST_VPD_LSB = 16;
	// input function codes
	localparam logic [3:0] FUNC_NONE = 4'h0;
	localparam logic [3:0] FUNC_FAULT_SNAPSHOT = 4'h2;
	localparam logic [3:0] FUNC_CURRENT_PD = 4'h3;
	localparam logic [3:0] FUNC_VOLTAGE_PD = 4'h4;
	localparam logic [3:0] FUNC_PROTECT = 4'h5;
	// reset values, standing in for the nonvolatile defaults
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [3:0] RST_CODE = 4'h0;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_VPD_SETTING = 8'h00;
	// cycles for the synchroniser to fill before the boot-time level sample
	localparam logic [1:0] SYNC_SETTLE_CYCLES = 2'h3;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== hdl/pin_edge_sync.sv
/*
 two-stage synchroniser for an asynchronous pin, plus edge detection.
 assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ns
module pin_edge_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic stable;
	logic prev;

	// first stage feeds only the second [R09]
	always_ff @(posedge clk) begin
		if (reset) begin
			meta <= 1'b1;
			stable <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= pin;
			stable <= meta;
			prev <= stable;
		end
	end

	assign level = stable;
	assign rise = stable & ~prev; // [R09]
	assign fall = ~stable & prev; // [R09]
endmodule

// ===== hdl/gpio_input_function_trigger.sv
/*
 pin-triggered action dispatcher for the general-purpose input pin,
 with an axi4-lite register slave for configuration and status.
 assumes pin input is asynchronous; all else runs on clk.
*/
// Overview of operation
// R01 - code 0010: falling edge fires fault snapshot on all channels; rising does nothing
// R02 - code 0011: falling powers down selected current outputs, rising powers up
// R03 - code 0100: falling powers down selected voltage outputs, rising powers up
// R04 - voltage power-down applies each channel's own pulldown or high-impedance setting
// R05 - code 0101: falling edge fires protect action on all channels
// R06 - no dispatch unless the input direction enable bit is one
// R07 - software control of a function is ignored while the pin owns it
// R08 - after reset the pin level is sampled once and its command run
// R09 - pin passes two flip-flops before edge detection; one action per edge
`timescale 1ns/1ns
module gpio_input_function_trigger #(
	parameter int CHANNELS = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic gpio_pin,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic fault_snapshot,
	output logic protect_trigger,
	output logic [CHANNELS-1:0] current_output_powerdown,
	output logic [CHANNELS-1:0] voltage_output_powerdown,
	output logic [CHANNELS-1:0] voltage_pulldown_enable,
	output logic [CHANNELS-1:0] voltage_hiz_enable
);
	typedef enum logic [1:0] {boot_settle, boot_fire, run} boot_state_t;

	boot_state_t state;
	boot_state_t next_state;
	logic [1:0] settle_count;
	logic pin_level;
	logic pin_rise;
	logic pin_fall;

	// configuration and state
	logic input_direction_enable;
	logic [3:0] input_function_code;
	logic [CHANNELS-1:0] input_channel_mask;
	logic [CHANNELS-1:0] voltage_powerdown_setting;
	logic [CHANNELS-1:0] ipd_state;
	logic [CHANNELS-1:0] vpd_state;

	// bus holding registers
	logic have_aw;
	logic have_w;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	pin_edge_sync sync_inst (
		.clk(clk),
		.reset(reset),
		.pin(gpio_pin),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// boot sequencer: wait for synchroniser to fill, then act on level once
	always_comb begin
		next_state = state;
		case (state)
			boot_settle: begin
				if (settle_count == gpi_trigger_pkg::SYNC_SETTLE_CYCLES)
					next_state = boot_fire;
			end
			boot_fire: next_state = run;
			run: next_state = run;
			default: next_state = boot_settle;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= boot_settle;
			settle_count <= 2'h0;
		end else begin
			state <= next_state;
			if (state == boot_settle)
				settle_count <= settle_count + 2'h1;
		end
	end

	// a level sampled at boot counts as the matching edge [R08]
	wire boot_low = (state == boot_fire) & ~pin_level; // [R08]
	wire boot_high = (state == boot_fire) & pin_level; // [R08]
	// edges are only dispatched once boot is over, so none fires twice [R09]
	wire ev_fall = input_direction_enable & ((state == run & pin_fall) | boot_low); // [R06]
	wire ev_rise = input_direction_enable & ((state == run & pin_rise) | boot_high); // [R06]

	wire pin_owns_fault = input_direction_enable & (input_function_code == gpi_trigger_pkg::FUNC_FAULT_SNAPSHOT);
	wire pin_owns_ipd = input_direction_enable & (input_function_code == gpi_trigger_pkg::FUNC_CURRENT_PD);
	wire pin_owns_vpd = input_direction_enable & (input_function_code == gpi_trigger_pkg::FUNC_VOLTAGE_PD);
	wire pin_owns_protect = input_direction_enable & (input_function_code == gpi_trigger_pkg::FUNC_PROTECT);

	// write decode
	wire do_write = have_aw & have_w & ~s_axi_bvalid;
	wire wr_config = do_write & (wr_addr == gpi_trigger_pkg::ADDR_CONFIG);
	wire wr_vpd_setting = do_write & (wr_addr == gpi_trigger_pkg::ADDR_VPD_SETTING);
	wire wr_sw = do_write & (wr_addr == gpi_trigger_pkg::ADDR_SW_CONTROL);
	wire wr_status = do_write & (wr_addr == gpi_trigger_pkg::ADDR_STATUS);
	wire wr_hit = wr_config | wr_vpd_setting | wr_sw | wr_status;
	wire [31:0] byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	logic [31:0] cfg_word;
	logic [31:0] sw_word;
	logic [31:0] status_word;
	wire [31:0] next_cfg = (cfg_word & ~byte_mask) | (wr_data & byte_mask);
	wire [31:0] next_sw = (sw_word & ~byte_mask) | (wr_data & byte_mask);
	wire [31:0] vpd_word = {{(32-CHANNELS){1'b0}}, voltage_powerdown_setting};
	wire [31:0] next_vpd_word = (vpd_word & ~byte_mask) | (wr_data & byte_mask);

	// software action pulses, refused while the pin owns them [R07]
	wire sw_fault = wr_sw & wr_strb[0] & wr_data[gpi_trigger_pkg::SW_FAULT_BIT] & ~pin_owns_fault; // [R07]
	wire sw_protect = wr_sw & wr_strb[0] & wr_data[gpi_trigger_pkg::SW_PROTECT_BIT] & ~pin_owns_protect; // [R07]

	// words built in processes: a function in a continuous assign would miss field changes
	always_comb begin
		cfg_word = 32'h0;
		cfg_word[gpi_trigger_pkg::CFG_ENABLE_BIT] = input_direction_enable;
		cfg_word[gpi_trigger_pkg::CFG_CODE_LSB +: 4] = input_function_code;
		cfg_word[gpi_trigger_pkg::CFG_MASK_LSB +: CHANNELS] = input_channel_mask;
	end

	always_comb begin
		sw_word = 32'h0;
		sw_word[gpi_trigger_pkg::SW_IPD_LSB +: CHANNELS] = ipd_state;
		sw_word[gpi_trigger_pkg::SW_VPD_LSB +: CHANNELS] = vpd_state;
	end

	always_comb begin
		status_word = 32'h0;
		status_word[gpi_trigger_pkg::ST_LEVEL_BIT] = pin_level;
		status_word[gpi_trigger_pkg::ST_BOOT_DONE_BIT] = (state == run);
		status_word[gpi_trigger_pkg::ST_IPD_LSB +: CHANNELS] = ipd_state;
		status_word[gpi_trigger_pkg::ST_VPD_LSB +: CHANNELS] = vpd_state;
	end

	// read decode
	wire rd_config = s_axi_araddr == gpi_trigger_pkg::ADDR_CONFIG;
	wire rd_vpd_setting = s_axi_araddr == gpi_trigger_pkg::ADDR_VPD_SETTING;
	wire rd_sw = s_axi_araddr == gpi_trigger_pkg::ADDR_SW_CONTROL;
	wire rd_status = s_axi_araddr == gpi_trigger_pkg::ADDR_STATUS;
	wire rd_hit = rd_config | rd_vpd_setting | rd_sw | rd_status;
	wire [31:0] rd_word = rd_config ? cfg_word :
		rd_vpd_setting ? vpd_word :
		rd_sw ? sw_word :
		rd_status ? status_word : 32'h0;

	// configuration registers
	always_ff @(posedge clk) begin
		if (reset) begin
			input_direction_enable <= gpi_trigger_pkg::RST_ENABLE;
			input_function_code <= gpi_trigger_pkg::RST_CODE;
			input_channel_mask <= gpi_trigger_pkg::RST_MASK[CHANNELS-1:0];
			voltage_powerdown_setting <= gpi_trigger_pkg::RST_VPD_SETTING[CHANNELS-1:0];
		end else begin
			if (wr_config) begin
				input_direction_enable <= next_cfg[gpi_trigger_pkg::CFG_ENABLE_BIT];
				input_function_code <= next_cfg[gpi_trigger_pkg::CFG_CODE_LSB +: 4];
				input_channel_mask <= next_cfg[gpi_trigger_pkg::CFG_MASK_LSB +: CHANNELS];
			end
			if (wr_vpd_setting)
				voltage_powerdown_setting <= next_vpd_word[CHANNELS-1:0];
		end
	end

	// global action pulses
	always_ff @(posedge clk) begin
		if (reset) begin
			fault_snapshot <= 1'b0;
			protect_trigger <= 1'b0;
		end else begin
			fault_snapshot <= (pin_owns_fault & ev_fall) | sw_fault; // [R01]
			protect_trigger <= (pin_owns_protect & ev_fall) | sw_protect; // [R05]
		end
	end

	// per-channel power state and termination
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
			always_ff @(posedge clk) begin
				if (reset) begin
					ipd_state[ch] <= 1'b0;
					vpd_state[ch] <= 1'b0;
				end else begin
					if (pin_owns_ipd) begin
						if (input_channel_mask[ch] & ev_fall)
							ipd_state[ch] <= 1'b1; // [R02]
						else if (input_channel_mask[ch] & ev_rise)
							ipd_state[ch] <= 1'b0; // [R02]
					end else if (wr_sw) begin
						ipd_state[ch] <= next_sw[gpi_trigger_pkg::SW_IPD_LSB + ch]; // [R07]
					end
					if (pin_owns_vpd) begin
						if (input_channel_mask[ch] & ev_fall)
							vpd_state[ch] <= 1'b1; // [R03]
						else if (input_channel_mask[ch] & ev_rise)
							vpd_state[ch] <= 1'b0; // [R03]
					end else if (wr_sw) begin
						vpd_state[ch] <= next_sw[gpi_trigger_pkg::SW_VPD_LSB + ch]; // [R07]
					end
				end
			end
		end
	endgenerate

	// outputs lag state by one cycle so every pin comes from a flop
	always_ff @(posedge clk) begin
		if (reset) begin
			current_output_powerdown <= '0;
			voltage_output_powerdown <= '0;
			voltage_pulldown_enable <= '0;
			voltage_hiz_enable <= '0;
		end else begin
			current_output_powerdown <= ipd_state;
			voltage_output_powerdown <= vpd_state;
			voltage_pulldown_enable <= vpd_state & voltage_powerdown_setting; // [R04]
			voltage_hiz_enable <= vpd_state & ~voltage_powerdown_setting; // [R04]
		end
	end

	// axi write channels: address and data taken in either order
	always_ff @(posedge clk) begin
		if (reset) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= gpi_trigger_pkg::AXI_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				have_aw <= 1'b1;
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				have_w <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? gpi_trigger_pkg::AXI_OKAY : gpi_trigger_pkg::AXI_SLVERR;
			end
			// ready again only after the response, so one write at a time
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// axi read channel
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= gpi_trigger_pkg::AXI_OKAY;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? gpi_trigger_pkg::AXI_OKAY : gpi_trigger_pkg::AXI_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ===== bench/pin_source.sv
/*
 board-side source of the general-purpose pin.
 assumes the bench sets level_req just after a clock edge.
*/
`timescale 1ns/1ns
module pin_source (
	input wire logic clk,
	input wire logic level_req,
	output logic gpio_pin
);
	// lands off the edge, so the synchroniser sees a truly async change
	initial gpio_pin = 1'b1;
	always @(posedge clk) gpio_pin <= #3 level_req;
endmodule

// ===== bench/gpio_trigger_sva.sv
/*
 port checker for the pin-triggered dispatcher.
 assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
module gpio_trigger_checker #(
	parameter int CHANNELS = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic fault_snapshot,
	input wire logic protect_trigger,
	input wire logic [CHANNELS-1:0] current_output_powerdown,
	input wire logic [CHANNELS-1:0] voltage_output_powerdown,
	input wire logic [CHANNELS-1:0] voltage_pulldown_enable,
	input wire logic [CHANNELS-1:0] voltage_hiz_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
	property p_fault_pulse; fault_snapshot |=> !fault_snapshot; endproperty
	property p_prot_pulse; protect_trigger |=> !protect_trigger; endproperty
	property p_vpd_split; (voltage_pulldown_enable | voltage_hiz_enable) == voltage_output_powerdown; endproperty
	property p_vpd_excl; (voltage_pulldown_enable & voltage_hiz_enable) == '0; endproperty
	property p_boot_quiet;
		$fell(reset) |-> !fault_snapshot && !protect_trigger && current_output_powerdown == '0
			&& voltage_output_powerdown == '0;
	endproperty
	property p_wresp; s_wtake |-> ##[1:3] s_axi_bvalid; endproperty
	property p_rresp; s_rtake |=> s_axi_rvalid; endproperty
	property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_fault_pulse: assert property (p_fault_pulse)
		else $error("fault pulse too long");
	a_prot_pulse: assert property (p_prot_pulse)
		else $error("protect pulse too long");
	a_vpd_split: assert property (p_vpd_split)
		else $error("voltage termination mismatch");
	a_vpd_excl: assert property (p_vpd_excl)
		else $error("pulldown and hiz together");
	a_boot_quiet: assert property (p_boot_quiet)
		else $error("action active out of reset");
	a_wresp: assert property (p_wresp)
		else $error("write response late");
	a_rresp: assert property (p_rresp)
		else $error("read response late");
	a_wblock: assert property (p_wblock)
		else $error("write taken while response pending");
endmodule

// ===== bench/gpio_input_function_trigger_test.sv
/*
 self-checking bench for the pin-triggered dispatcher.
 assumes the design package, pin_source and checker compile first.
*/
`timescale 1ns/1ns
module gpio_input_function_trigger_test;
	localparam logic [7:0] addr_cfg = gpi_trigger_pkg::ADDR_CONFIG;
	localparam logic [7:0] addr_vpd = gpi_trigger_pkg::ADDR_VPD_SETTING;
	localparam logic [7:0] addr_sw = gpi_trigger_pkg::ADDR_SW_CONTROL;
	localparam logic [7:0] addr_st = gpi_trigger_pkg::ADDR_STATUS;
	localparam logic [1:0] ok = gpi_trigger_pkg::AXI_OKAY;
	logic clk = 1'b0, reset = 1'b1, pin_req = 1'b1, gpio_pin;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault_snapshot, protect_trigger;
	logic [1:0] s_axi_bresp, s_axi_rresp, m;
	logic [1:0] current_output_powerdown, voltage_output_powerdown, voltage_pulldown_enable, voltage_hiz_enable;
	logic [33:0] notes[$];
	int mismatches = 0, samples_checked = 0, faults = 0, protects = 0;
	always #5 clk = ~clk;
	pin_source pin_source_inst (.clk, .level_req(pin_req), .gpio_pin);
	gpio_input_function_trigger #(.CHANNELS(2)) gpio_input_function_trigger_inst (.clk, .reset, .gpio_pin,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_snapshot, .protect_trigger, .current_output_powerdown,
		.voltage_output_powerdown, .voltage_pulldown_enable, .voltage_hiz_enable);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_up(input int n);
		if (n >= 50) begin
			mismatches++;
			complete_run;
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		give_up(n);
		s_axi_bready <= 1'b0;
		check("bresp", {s_axi_bresp, 32'h0}, {r, 32'h0});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge clk);
		notes.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		give_up(n);
		s_axi_rready <= 1'b0;
	endtask
	// pin levels held 12 cycles, well past the 3-cycle minimum
	task automatic drive_pin(input logic v);
		@(posedge clk);
		pin_req <= v;
		repeat (12) @(posedge clk);
	endtask
	task automatic outs(input logic [5:0] e);
		check("voltage_output", 34'({voltage_output_powerdown, voltage_pulldown_enable, voltage_hiz_enable}), 34'(e));
	endtask
	always @(posedge clk) begin
		if (fault_snapshot === 1'b1) faults++;
		if (protect_trigger === 1'b1) protects++;
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) check("rdata", {s_axi_rresp, s_axi_rdata}, notes.pop_front());
	end
	initial begin
		rnd = lfsr(32'h4bf28e86);
		m = {rnd[9], 1'b1};
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		axr(addr_st, 32'h3, ok);
		axr(addr_cfg, 32'h0, ok);
		axr(addr_vpd, 32'h0, ok);
		axr(8'h10, 32'h0, gpi_trigger_pkg::AXI_SLVERR);
		axw(8'h10, 32'hffffffff, gpi_trigger_pkg::AXI_SLVERR);
		axw(addr_sw, 32'h1, ok);
		axw(addr_cfg, 32'h21, ok);
		drive_pin(1'b0);
		drive_pin(1'b1);
		axw(addr_sw, 32'h1, ok);
		@(posedge clk);
		check("fault", 34'(faults), 34'd2);
		axw(addr_cfg, 32'h51, ok);
		drive_pin(1'b0);
		drive_pin(1'b1);
		axw(addr_sw, 32'h2, ok);
		@(posedge clk);
		check("protect", 34'(protects), 34'd1);
		axw(addr_cfg, 32'h31 | {m, 8'h0}, ok);
		drive_pin(1'b0);
		axr(addr_st, 32'h2 | {m, 8'h0}, ok);
		axw(addr_sw, 32'h300, ok);
		axr(addr_st, 32'h2 | {m, 8'h0}, ok);
		drive_pin(1'b1);
		axr(addr_st, 32'h3, ok);
		axw(addr_vpd, 32'h1, ok);
		axw(addr_cfg, 32'h341, ok);
		drive_pin(1'b0);
		outs(6'b110110);
		axr(addr_st, 32'h30002, ok);
		drive_pin(1'b1);
		outs(6'b000000);
		axw(addr_cfg, 32'h340, ok);
		drive_pin(1'b0);
		outs(6'b000000);
		// second reset with the pin held low: the boot sample acts as a falling edge
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		axw(addr_cfg, 32'h31 | {m, 8'h0}, ok);
		repeat (8) @(posedge clk);
		check("boot", 34'(current_output_powerdown), 34'(m));
		drive_pin(1'b1);
		check("powerup", 34'(current_output_powerdown), 34'd0);
		check("notes", 34'(notes.size()), 34'd0);
		complete_run;
	end
endmodule
bind gpio_input_function_trigger gpio_trigger_checker #(.CHANNELS(CHANNELS)) gpio_trigger_checker_inst (.clk, .reset,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .fault_snapshot, .protect_trigger, .current_output_powerdown, .voltage_output_powerdown,
	.voltage_pulldown_enable, .voltage_hiz_enable);
